// >>> rtl/io_bank_pkg.sv
// constants and register map for the six-port bidirectional io bank
package io_bank_pkg;
   localparam int PORT_COUNT = 6;
   localparam int PORT_WIDTH = 8;
   localparam int ADDR_WIDTH = 5;
   localparam int REGS_PER_PORT = 3;
   // register offsets, three per port: data, direction, option
   localparam logic [4:0] PORT_A_DATA_OFS = 5'h00;
   localparam logic [4:0] PORT_A_DIRECTION_OFS = 5'h01;
   localparam logic [4:0] PORT_A_OPTION_OFS = 5'h02;
   localparam logic [4:0] PORT_B_DATA_OFS = 5'h03;
   localparam logic [4:0] PORT_B_DIRECTION_OFS = 5'h04;
   localparam logic [4:0] PORT_B_OPTION_OFS = 5'h05;
   localparam logic [4:0] PORT_C_DATA_OFS = 5'h06;
   localparam logic [4:0] PORT_C_DIRECTION_OFS = 5'h07;
   localparam logic [4:0] PORT_C_OPTION_OFS = 5'h08;
   localparam logic [4:0] PORT_D_DATA_OFS = 5'h09;
   localparam logic [4:0] PORT_D_DIRECTION_OFS = 5'h0A;
   localparam logic [4:0] PORT_D_OPTION_OFS = 5'h0B;
   localparam logic [4:0] PORT_E_DATA_OFS = 5'h0C;
   localparam logic [4:0] PORT_E_DIRECTION_OFS = 5'h0D;
   localparam logic [4:0] PORT_E_OPTION_OFS = 5'h0E;
   localparam logic [4:0] PORT_F_DATA_OFS = 5'h0F;
   localparam logic [4:0] PORT_F_DIRECTION_OFS = 5'h10;
   localparam logic [4:0] PORT_F_OPTION_OFS = 5'h11;
   // extra control registers placed after the port map
   localparam logic [4:0] SENSE_OFS = 5'h12;
   localparam logic [4:0] IRQ_STATUS_OFS = 5'h13;
   localparam logic [4:0] IRQ_MASK_OFS = 5'h14;
   localparam logic [4:0] LAST_PORT_OFS = PORT_F_OPTION_OFS;
   // reset values
   localparam logic [7:0] PORT_REG_RESET = 8'h00;
   localparam logic [1:0] SENSE_RESET = 2'h0;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // interrupt-capable pin: bit 3 of port A and of port B
   localparam int IRQ_PIN_BIT = 3;
   localparam int IRQ_PORT_A = 0;
   localparam int IRQ_PORT_B = 1;
   localparam int IRQ_LINES = 2;
   // sensitivity encoding per line
   localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
   localparam logic [1:0] SENSE_RISE = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_BOTH = 2'h3;
endpackage

// >>> rtl/io_bank.sv
// six-port bidirectional io bank with pin interrupts and wake-up
`timescale 1ns/1ps

// Functional notes
// RULE1: bit n of each data, direction and option register belongs to pin n.
// RULE2: reading data of an input pin returns the synchronised pin level.
// RULE3: an output pin is driven from the latch and reads back the latch.
// RULE4: interrupt pins of one vector are detected by sensitivity then ORed.
// RULE5: software keeps alternate functions off pins set as interrupt input.
// RULE6: software sets analog pins to floating input before conversion.
// RULE7: software changes direction and option only along safe transitions.
// RULE8: in wait the ports run unchanged and a pin interrupt exits wait.
// RULE9: in halt the ports hold state and a pin interrupt exits halt.
// RULE10: a pin interrupt needs interrupt input mode and a clear cpu mask.
// RULE11: the pin interrupt has no event flag and wakes from wait and halt; here each line also sets a sticky status flag at IRQ_STATUS_OFS.
// RULE12: dir 0 gives floating or pull-up input, dir 1 open-drain or push-pull.
// RULE13: pins three of ports a and b with option 1 are floating interrupt in.
// RULE14: all port registers clear to zero on reset.
// RULE15: ports map as consecutive data, direction, option triples from a to f.
// RULE16: a register write acts on the pins from the next clock edge; here the pads follow the register one edge later, two edges after the write.
module io_bank
   import io_bank_pkg::*;
#(
   parameter int PW = io_bank_pkg::PORT_WIDTH
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [io_bank_pkg::ADDR_WIDTH-1:0] addr, // register index
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic [io_bank_pkg::PORT_COUNT*PW-1:0] pin_in, // pad levels
   output logic [io_bank_pkg::PORT_COUNT*PW-1:0] pin_out, // pad drive value
   output logic [io_bank_pkg::PORT_COUNT*PW-1:0] pin_oe, // pad drive enable
   output logic [io_bank_pkg::PORT_COUNT*PW-1:0] pin_pullup, // pull-up on
   input wire logic cpu_irq_masked, // cpu condition code mask set
   input wire logic [1:0] vector_fetch, // ack pulses per vector
   output logic [1:0] ext_irq_req, // request per vector to cpu
   output logic wake_req, // exit wait or halt
   output logic irq // masked status interrupt
);
   import io_bank_pkg::*;

   localparam int NP = PORT_COUNT;
   localparam int NB = NP * PW;

   typedef struct packed {
      logic [NP-1:0][PW-1:0] data;
      logic [NP-1:0][PW-1:0] dir;
      logic [NP-1:0][PW-1:0] opt;
      logic [NB-1:0] sync1;
      logic [NB-1:0] sync2;
      logic [IRQ_LINES-1:0] irq_prev;
      logic [IRQ_LINES-1:0][1:0] sense;
      logic [IRQ_LINES-1:0] pend;
      logic [IRQ_LINES-1:0] status;
      logic [IRQ_LINES-1:0] mask;
      logic [7:0] rdata;
      logic [NB-1:0] out;
      logic [NB-1:0] oe;
      logic [NB-1:0] pull;
      logic [IRQ_LINES-1:0] req;
      logic wake;
      logic irq;
   } state_type;

   state_type s_q, s_d;

   // true where a pin is interrupt capable
   function automatic logic is_irq_pin(input int p, input int b);
      return (p == IRQ_PORT_A || p == IRQ_PORT_B) && b == IRQ_PIN_BIT;
   endfunction

   // detection of one line from its sensitivity
   function automatic logic detect(input logic [1:0] sn, input logic now,
                                   input logic prev);
      unique case (sn)
         SENSE_FALL_LOW: return !now;
         SENSE_RISE: return now && !prev;
         SENSE_FALL: return !now && prev;
         SENSE_BOTH: return now != prev;
      endcase
   endfunction

   logic [IRQ_LINES-1:0] irq_level;
   logic [IRQ_LINES-1:0] irq_en;
   logic [IRQ_LINES-1:0] hit;
   logic [2:0] port_sel;
   logic [1:0] reg_sel;
   logic in_map;

   // decode index into port and register kind
   always_comb begin
      port_sel = 3'(addr / REGS_PER_PORT);
      reg_sel = 2'(addr % REGS_PER_PORT);
      in_map = addr <= LAST_PORT_OFS; // [RULE15]
   end

   // interrupt enable and edge or level detection per line
   always_comb begin
      for (int i = 0; i < IRQ_LINES; i++) begin
         irq_level[i] = s_q.sync2[i*PW + IRQ_PIN_BIT];
         // dir 0 with option 1 on pin three selects interrupt input
         irq_en[i] = !s_q.dir[i][IRQ_PIN_BIT] &&
                     s_q.opt[i][IRQ_PIN_BIT]; // [RULE13] [RULE11]
         hit[i] = irq_en[i] &&
                  detect(s_q.sense[i], irq_level[i], s_q.irq_prev[i]);
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      // two-flop synchroniser; stage one feeds only stage two
      s_d.sync1 = pin_in;
      s_d.sync2 = s_q.sync1;
      s_d.irq_prev = irq_level;
      s_d.rdata = 8'h00;
      if (wr && in_map) begin
         unique case (reg_sel)
            2'd0: s_d.data[port_sel] = wdata; // [RULE1]
            2'd1: s_d.dir[port_sel] = wdata; // [RULE1]
            default: s_d.opt[port_sel] = wdata; // [RULE1]
         endcase
      end
      if (wr && addr == SENSE_OFS) begin
         s_d.sense[0] = wdata[1:0];
         s_d.sense[1] = wdata[3:2];
      end
      if (wr && addr == IRQ_MASK_OFS) begin
         s_d.mask = wdata[IRQ_LINES-1:0];
      end
      // request latch: cleared on fetch or sensitivity rewrite, set wins
      for (int i = 0; i < IRQ_LINES; i++) begin
         if (vector_fetch[i] || (wr && addr == SENSE_OFS)) begin
            s_d.pend[i] = 1'b0;
         end
         if (wr && addr == IRQ_STATUS_OFS && wdata[i]) begin
            s_d.status[i] = 1'b0;
         end
         if (hit[i]) begin
            s_d.pend[i] = 1'b1; // [RULE4]
            s_d.status[i] = 1'b1;
         end
      end
      // read data, one cycle after the strobe
      if (rd) begin
         if (in_map) begin
            unique case (reg_sel)
               2'd0: begin
                  for (int b = 0; b < PW; b++) begin
                     s_d.rdata[b] = s_q.dir[port_sel][b] ?
                        s_q.data[port_sel][b] : // [RULE3]
                        s_q.sync2[port_sel*PW + b]; // [RULE2]
                  end
               end
               2'd1: s_d.rdata = s_q.dir[port_sel];
               default: s_d.rdata = s_q.opt[port_sel];
            endcase
         end else if (addr == SENSE_OFS) begin
            s_d.rdata = {4'h0, s_q.sense[1], s_q.sense[0]};
         end else if (addr == IRQ_STATUS_OFS) begin
            s_d.rdata = {6'h00, s_q.status};
         end else if (addr == IRQ_MASK_OFS) begin
            s_d.rdata = {6'h00, s_q.mask};
         end
      end
      // pad controls follow registers one edge later; low power untouched
      for (int p = 0; p < NP; p++) begin
         for (int b = 0; b < PW; b++) begin
            s_d.out[p*PW+b] = s_q.data[p][b]; // [RULE3] [RULE16]
            // push-pull drives both levels, open drain only the low
            s_d.oe[p*PW+b] = s_q.dir[p][b] &&
               (s_q.opt[p][b] || !s_q.data[p][b]); // [RULE12] [RULE8]
            s_d.pull[p*PW+b] = !s_q.dir[p][b] && s_q.opt[p][b] &&
               !is_irq_pin(p, b); // [RULE12] [RULE13] [RULE9]
         end
      end
      // cpu mask gates requests; wake ignores it so halt can exit
      s_d.req = s_q.pend & {IRQ_LINES{!cpu_irq_masked}}; // [RULE10]
      s_d.wake = |s_q.pend; // [RULE8] [RULE9] [RULE11]
      s_d.irq = |(s_q.status & s_q.mask);
      if (!rst_n) begin
         s_d = '0; // [RULE14]
         s_d.data = {NP{PORT_REG_RESET}};
         s_d.dir = {NP{PORT_REG_RESET}};
         s_d.opt = {NP{PORT_REG_RESET}};
      end
   end

   // single state register
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign rdata = s_q.rdata;
   assign pin_out = s_q.out;
   assign pin_oe = s_q.oe;
   assign pin_pullup = s_q.pull;
   assign ext_irq_req = s_q.req;
   assign wake_req = s_q.wake;
   assign irq = s_q.irq;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   reset_clear_a: assert property ($rose(rst_n) |->
      pin_oe == '0 && pin_pullup == '0) // [RULE14]
      else $error("pads not quiet after reset");
   write_drive_a: assert property (wr && addr == PORT_C_DIRECTION_OFS &&
      wdata == 8'hFF && !rd |=> ##1 pin_oe[2*PW +: PW] ==
      (~s_q.data[2] | s_q.opt[2])) // [RULE16]
      else $error("direction write not on pads");
   input_read_a: assert property (rd && addr == PORT_D_DATA_OFS &&
      s_q.dir[3] == 8'h00 |=> rdata == $past(s_q.sync2[3*PW +: PW]))
      // [RULE2]
      else $error("input read not pin level");
   output_read_a: assert property (rd && addr == PORT_E_DATA_OFS &&
      s_q.dir[4] == 8'hFF |=> rdata == $past(s_q.data[4])) // [RULE3]
      else $error("output read not latch");
   irq_pin_nopull_a: assert property (pin_pullup[IRQ_PIN_BIT] == 1'b0)
      // [RULE13]
      else $error("pull-up on interrupt pin");
   mask_gate_a: assert property (cpu_irq_masked |=> ext_irq_req == '0)
      // [RULE10]
      else $error("request passed cpu mask");
   wake_hit_a: assert property (hit[0] |-> ##2 wake_req) // [RULE8]
      else $error("no wake after pin event");
   no_enable_a: assert property (!irq_en[1] && !s_q.pend[1] |=>
      !s_q.pend[1]) // [RULE11]
      else $error("request without enable");
   pullup_mode_a: assert property (!s_q.dir[2][0] && s_q.opt[2][0] |=>
      pin_pullup[2*PW]) // [RULE12]
      else $error("pull-up input not pulled");
   or_combine_a: assert property (hit[1] |=> s_q.pend[1]) // [RULE4]
      else $error("event lost");

   // request latch: set wins over fetch and sensitivity rewrite
   status_set_a: assert property ( // [RULE4]
      hit[0] |=> s_q.status[0])
      else $error("status event lost");
   fetch_clear_a: assert property ( // [RULE4]
      vector_fetch[0] && !hit[0] |=> !s_q.pend[0])
      else $error("fetch left request");
   sense_clear_a: assert property ( // [RULE4]
      wr && addr == SENSE_OFS && !hit[1] |=> !s_q.pend[1])
      else $error("rewrite left request");
   pend_hold_a: assert property ( // [RULE4]
      s_q.pend[0] && !vector_fetch[0] && !(wr && addr == SENSE_OFS)
      |=> s_q.pend[0])
      else $error("request dropped");
   level_repend_a: assert property ( // [RULE4]
      s_q.sense[0] == SENSE_FALL_LOW && irq_en[0] && !irq_level[0]
      |=> s_q.pend[0])
      else $error("low level not pending");
   sense_write_a: assert property ( // [RULE4]
      wr && addr == SENSE_OFS |=> s_q.sense[1] == $past(wdata[3:2]))
      else $error("sensitivity not stored");

   // status is sticky until a one is written; a new event beats the clear
   status_clear_a: assert property ( // [RULE4]
      wr && addr == IRQ_STATUS_OFS && wdata[1] && !hit[1]
      |=> !s_q.status[1])
      else $error("status not cleared");
   mask_write_a: assert property ( // [RULE4]
      wr && addr == IRQ_MASK_OFS |=> s_q.mask == $past(wdata[1:0]))
      else $error("mask not stored");
   irq_on_a: assert property ( // [RULE4]
      |(s_q.status & s_q.mask) |=> irq)
      else $error("irq missing");
   irq_off_a: assert property ( // [RULE4]
      !(|(s_q.status & s_q.mask)) |=> !irq)
      else $error("irq without cause");

   // cpu side: requests obey the mask, wake does not
   req_follow_a: assert property ( // [RULE10]
      s_q.pend[0] && !cpu_irq_masked |=> ext_irq_req[0])
      else $error("request not passed");
   req_low_a: assert property ( // [RULE10]
      !s_q.pend[1] |=> !ext_irq_req[1])
      else $error("request without latch");
   wake_unmasked_a: assert property ( // [RULE9]
      s_q.pend[1] |=> wake_req)
      else $error("no wake from line one");
   wake_low_a: assert property ( // [RULE11]
      !(|s_q.pend) |=> !wake_req)
      else $error("wake without request");
   out_no_irq_a: assert property ( // [RULE10]
      s_q.dir[1][IRQ_PIN_BIT] |-> !irq_en[1])
      else $error("output pin enabled as interrupt");

   // register reads and writes
   data_write_a: assert property ( // [RULE3]
      wr && addr == PORT_A_DATA_OFS |=> s_q.data[0] == $past(wdata))
      else $error("data write lost");
   dir_read_a: assert property ( // [RULE1]
      rd && addr == PORT_B_DIRECTION_OFS |=> rdata == $past(s_q.dir[1]))
      else $error("direction read wrong");
   opt_read_a: assert property ( // [RULE15]
      rd && addr == PORT_F_OPTION_OFS |=> rdata == $past(s_q.opt[5]))
      else $error("option read wrong");
   unmapped_read_a: assert property ( // [RULE15]
      rd && addr > IRQ_MASK_OFS |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property ( // [RULE1]
      !rd |=> rdata == 8'h00)
      else $error("read data without strobe");

   // pad modes; the synchroniser costs two edges of latency
   push_pull_a: assert property ( // [RULE12]
      s_q.dir[1][0] && s_q.opt[1][0] |=> pin_oe[PW] &&
      pin_out[PW] == $past(s_q.data[1][0]))
      else $error("push-pull not driven");
   open_drain_a: assert property ( // [RULE12]
      s_q.dir[3][7] && !s_q.opt[3][7] |=>
      pin_oe[3*PW+7] == !$past(s_q.data[3][7]))
      else $error("open drain drives high");
   input_float_a: assert property ( // [RULE12]
      !s_q.dir[4][2] |=> !pin_oe[4*PW+2])
      else $error("input pin driven");
   float_nopull_a: assert property ( // [RULE12]
      !s_q.dir[4][1] && !s_q.opt[4][1] |=> !pin_pullup[4*PW+1])
      else $error("floating input pulled");
   b3_nopull_a: assert property ( // [RULE13]
      pin_pullup[PW+IRQ_PIN_BIT] == 1'b0)
      else $error("pull-up on line one pin");
   sync_delay_a: assert property ( // [RULE2]
      $past(rst_n) && $past(rst_n, 2) |-> s_q.sync2 == $past(pin_in, 2))
      else $error("synchroniser latency wrong");

   cover_wake_c: cover property (hit[0] ##2 wake_req);
   cover_push_c: cover property (pin_oe[0] && pin_out[0]);
   cover_read_c: cover property (rd ##1 rdata != 8'h00);
   // fetch against a live request, and a wake while the cpu is masked
   cover_fetch_c: cover property (vector_fetch[0] && s_q.pend[0]);
   cover_halt_c: cover property (cpu_irq_masked && wake_req);
endmodule // io_bank

// >>> bench/pad_model.sv
// board-side pad model: resolves each pin from bank and board drive
`timescale 1ns/1ps
module pad_model #(
   parameter int N = 48
) (
   input wire logic clk, // core clock
   input wire logic [N-1:0] drv_val, // bank drive value
   input wire logic [N-1:0] drv_en, // bank drive enable
   input wire logic [N-1:0] pull_en, // bank pull-up on
   input wire logic [N-1:0] ext_val, // board drive value
   input wire logic [N-1:0] ext_en, // board drive enable
   output logic [N-1:0] pad // resolved pin level
);
   logic [N-1:0] last_q = '0;
   // bank wins; a floating pad flips so a stale value never reads back
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (drv_en[i])
            pad[i] = drv_val[i];
         else if (ext_en[i])
            pad[i] = ext_val[i];
         else if (pull_en[i])
            pad[i] = 1'b1;
         else
            pad[i] = ~last_q[i];
      end
   end
   // last level, for the floating case
   always_ff @(posedge clk) last_q <= pad;
endmodule // pad_model

// >>> bench/tb.sv
// self-checking bench: registers, pad modes and pin interrupts
`timescale 1ns/1ps
module tb;
   import io_bank_pkg::*;
   localparam int N = PORT_COUNT * PORT_WIDTH;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] addr = '0;
   logic [7:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [N-1:0] pin_in, pin_out, pin_oe, pin_pullup;
   logic [N-1:0] ext_val = '0;
   logic [N-1:0] ext_en = '1;
   logic cpu_irq_masked = 1'b0;
   logic [1:0] vector_fetch = '0;
   logic [1:0] ext_irq_req;
   logic wake_req, irq;
   int num_errors = 0;
   int n_checks = 0;
   int k, p, l;
   logic [7:0] d, dir, opt, dat, v;
   io_bank DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .cpu_irq_masked(cpu_irq_masked), .vector_fetch(vector_fetch),
      .ext_irq_req(ext_irq_req), .wake_req(wake_req), .irq(irq));
   pad_model #(.N(N)) pads (.clk(clk), .drv_val(pin_out), .drv_en(pin_oe),
      .pull_en(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
      .pad(pin_in));
   // 200 MHz core clock
   initial forever #2.5 clk = ~clk;
   task end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task wr_reg(input logic [4:0] a, input logic [7:0] x);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task rd_reg(input logic [4:0] a, output logic [7:0] x);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 x = rdata;
   endtask
   function automatic logic probe(input int s);
      return s < 2 ? ext_irq_req[s] : s == 2 ? wake_req : irq;
   endfunction
   // bounded wait; running out ends the run
   task wait_for(input int s, input logic want);
      for (int i = 0; i < 20 && probe(s) !== want; i++) @(posedge clk);
      #1 chk(probe(s), want);
      if (probe(s) !== want)
         end_of_test();
   endtask
   function automatic logic [7:0] pull_exp(input int q, input logic [7:0] r,
      input logic [7:0] o);
      logic [7:0] pu;
      pu = ~r & o;
      if (q == IRQ_PORT_A || q == IRQ_PORT_B)
         pu[IRQ_PIN_BIT] = 1'b0;
      return pu;
   endfunction
   task do_reset();
      rst_n <= 1'b0;
      // board drives every pin low so input reads are defined
      ext_en <= '1;
      ext_val <= '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 8'h15; a++) begin
         rd_reg(a[4:0], d);
         chk(d, 8'h00);
      end
      chk(pin_oe | pin_pullup | pin_out, '0);
      $display("test reset done");
   endtask
   initial begin
      #(5 * 100000);
      num_errors++;
      $display("unexpected at %0t: run too long", $time);
      end_of_test();
   end
   initial begin
      void'($urandom(88));
      do_reset();
      // random port setups, corner patterns at k 0, 1 and 6; board drives inputs
      for (k = 0; k < 12; k++) begin
         p = k % 6;
         dir = $urandom;
         opt = $urandom;
         dat = $urandom;
         v = $urandom;
         if (k < 2) {dir, opt} = 16'h00FF;
         if (k == 6) {dir, opt, dat} = 24'hFF0055;
         ext_en[p*8+:8] <= ~dir;
         ext_val[p*8+:8] <= v;
         wr_reg(5'(p * 3), dat); // latch before direction
         wr_reg(5'(p * 3 + 1), dir);
         wr_reg(5'(p * 3 + 2), opt);
         repeat (3) @(posedge clk);
         #1 chk(pin_oe[p*8+:8], dir & (opt | ~dat));
         chk(pin_pullup[p*8+:8], pull_exp(p, dir, opt));
         chk(pin_out[p*8+:8], dat);
         rd_reg(5'(p * 3 + 1), d);
         chk(d, dir);
         rd_reg(5'(p * 3 + 2), d);
         chk(d, opt);
         rd_reg(5'(p * 3), d);
         chk(d, (dir & dat) | (~dir & v));
      end
      wr_reg(5'h1F, 8'hFF);
      rd_reg(5'h1F, d);
      chk(d, 8'h00);
      $display("test ports done");
      // pin three of port a then b as rising-edge interrupt
      for (l = 0; l < 2; l++) begin
         ext_en[l*8+3] <= 1'b1; // no alternate use on this pin
         ext_val[l*8+3] <= 1'b0;
         wr_reg(5'(l * 3 + 1), 8'h00);
         wr_reg(5'(l * 3 + 2), 8'h00); // floating first
         wr_reg(SENSE_OFS, {4'h0, SENSE_RISE, SENSE_RISE});
         ext_val[l*8+3] <= 1'b1;
         repeat (8) @(posedge clk);
         #1 chk(wake_req, 1'b0);
         ext_val[l*8+3] <= 1'b0;
         wr_reg(5'(l * 3 + 2), 8'h08);
         repeat (4) @(posedge clk);
         wr_reg(SENSE_OFS, {4'h0, SENSE_RISE, SENSE_RISE});
         ext_val[l*8+3] <= 1'b1;
         wait_for(l, 1'b1);
         chk(wake_req, 1'b1);
         vector_fetch[l] <= 1'b1;
         @(posedge clk);
         vector_fetch[l] <= 1'b0;
         wait_for(l, 1'b0);
         rd_reg(IRQ_STATUS_OFS, d);
         chk(d[l], 1'b1);
         wr_reg(IRQ_MASK_OFS, 8'(1 << l));
         wait_for(3, 1'b1);
         wr_reg(IRQ_STATUS_OFS, 8'(1 << l));
         wait_for(3, 1'b0);
         // cpu mask set: wake still comes, no request
         cpu_irq_masked <= 1'b1;
         ext_val[l*8+3] <= 1'b0;
         repeat (4) @(posedge clk);
         ext_val[l*8+3] <= 1'b1;
         wait_for(2, 1'b1);
         chk(ext_irq_req[l], 1'b0);
         cpu_irq_masked <= 1'b0;
      end
      $display("test interrupts done");
      do_reset();
      end_of_test();
   end
endmodule // tb
